// ### src/pmrs_top.sv
// Purpose: low-power mode entry, wake-up and reset sequencing
// Assumes: core strobes are one-cycle pulses on clock
// Notes: long waits are parameters so simulation can shorten them
`timescale 1ns/100ps
module pmrs_top
	import pmrs_pkg::*;
#(
	parameter logic [CNT_W-1:0] PWRUP0  = PWRUP0_CYC[CNT_W-1:0],
	parameter logic [CNT_W-1:0] PWRUP1  = PWRUP1_CYC[CNT_W-1:0],
	parameter logic [CNT_W-1:0] PWRUP2  = PWRUP2_CYC[CNT_W-1:0],
	parameter logic [CNT_W-1:0] PWRUP3  = PWRUP3_CYC[CNT_W-1:0],
	parameter logic [CNT_W-1:0] PWRUP4  = PWRUP4_CYC[CNT_W-1:0],
	parameter int               OSC_DIV = 1
) (
	input  wire logic       clock,
	input  wire logic       rstn,
	// reset events
	input  wire logic       por_detect,
	input  wire logic       low_voltage_reset,
	input  wire logic       reset_pin_n,
	input  wire logic       wdt_reset,
	// wake events
	input  wire logic       wdt_timeout,
	input  wire logic [3:0] timer_expire,
	input  wire logic       port_change,
	input  wire logic [1:0] external_irq_pins,
	input  wire logic       low_voltage_detect,
	input  wire logic       cmp_change,
	input  wire logic       adc_done,
	// core writes and instructions
	input  wire logic       osc_wr,
	input  wire logic [1:0] op_mode_field,
	input  wire logic       stop_fast_osc_wdata,
	input  wire logic       fast_clock_select_wdata,
	input  wire logic       halt_instruction,
	input  wire logic       watchdog_clear_instruction,
	input  wire logic       irq_enabled,
	input  wire logic [3:0] timer_run_enable,
	// configuration
	input  wire logic [2:0] cfg_pwrup_sel,
	input  wire logic       cfg_startup_fast,
	input  wire logic       fast_crystal_mode,
	input  wire logic       mid_crystal_mode,
	input  wire logic       slow_crystal_mode,
	// results
	output logic            core_reset,
	output logic            cpu_run,
	output pmrs_mode_t      sys_mode,
	output logic            fast_osc_en,
	output logic            slow_osc_en,
	output logic [3:0]      timer_run,
	output logic            periph_run,
	output logic            stop_fast_osc,
	output logic            fast_clock_select,
	output logic            timeout_flag,
	output logic            powerdown_flag,
	output logic            wdt_clear,
	output logic            wake_pulse,
	output logic            wake_to_vector,
	output logic [10:0]     wake_vector_addr
);
	// parameter check
	if (OSC_DIV < 1 || OSC_DIV > 255) begin : g_chk
		$error("OSC_DIV out of range");
	end

	pmrs_cnt_if cif ();           // delay counter link

	// pins from outside the clock domain
	logic       por_s;            // synchronised power-on
	logic       lvr_s;            // synchronised low voltage
	logic       rst_pin_n_s;      // synchronised reset pin
	logic [1:0] ext_s;            // synchronised external irqs

	pmrs_sync #(.W(5), .INIT(5'h1c)) u_sync (
		.clock (clock),
		.rstn  (rstn),
		.d     ({por_detect, low_voltage_reset, reset_pin_n, external_irq_pins}),
		.q     ({por_s, lvr_s, rst_pin_n_s, ext_s})
	);

	pmrs_delay u_delay (
		.clock (clock),
		.rstn  (rstn),
		.cif   (cif.cnt)
	);

	// oscillator cycle divider
	logic [7:0] div_cnt;          // divider count
	logic [7:0] next_div_cnt;
	logic       osc_tick;         // one system-oscillator cycle
	logic       next_osc_tick;

	// state
	pmrs_state_t state;           // sequencer state
	pmrs_state_t next_state;
	logic        irq_at_entry;    // interrupt enable at entry
	logic        next_irq_at_entry;
	logic        next_core_reset;
	logic        next_cpu_run;
	pmrs_mode_t  next_sys_mode;
	logic        next_fast_osc_en;
	logic        next_slow_osc_en;
	logic [3:0]  next_timer_run;
	logic        next_periph_run;
	logic        next_stop_fast_osc;
	logic        next_fast_clock_select;
	logic        next_timeout_flag;
	logic        next_powerdown_flag;
	logic        next_wdt_clear;
	logic        next_wake_pulse;
	logic        next_wake_to_vector;
	logic [10:0] next_wake_vector_addr;

	// decoded events
	logic reset_event;            // any reset cause present
	logic in_halt;                // halt or its wake wait
	logic enter_halt;             // halt request this cycle
	logic enter_standby;          // standby request this cycle
	logic wake_standby;           // any standby wake source
	logic wake_halt;              // any halt wake source
	logic any_xtal;               // a crystal mode configured
	logic [CNT_W-1:0] pwrup_cnt;  // selected power-up wait
	logic [CNT_W-1:0] ost_cnt;    // selected start-up wait

	// reset causes
	assign reset_event = por_s || lvr_s || !rst_pin_n_s || wdt_reset;
	assign in_halt     = (state == ST_HALT) || (state == ST_STAB);
	assign enter_halt  = halt_instruction || (osc_wr && op_mode_field == OP_MODE_FIELD_HALT);
	assign enter_standby = osc_wr && op_mode_field == OP_MODE_FIELD_STANDBY;
	// standby wakes on every listed event, a timer expiry only where its run enable is set
	assign wake_standby = |(timer_expire & timer_run_enable) || wdt_timeout
		|| port_change || |ext_s || low_voltage_detect || cmp_change || adc_done;
	// halt wakes on the short list only
	assign wake_halt = wdt_timeout || port_change || |ext_s;
	assign any_xtal  = fast_crystal_mode || mid_crystal_mode || slow_crystal_mode;

	// power-up and start-up wait selection
	always_comb begin
		unique case (cfg_pwrup_sel)
			3'h0: pwrup_cnt = PWRUP0;
			3'h1: pwrup_cnt = PWRUP1;
			3'h2: pwrup_cnt = PWRUP2;
			3'h3: pwrup_cnt = PWRUP3;
			default: pwrup_cnt = PWRUP4;
		endcase
		ost_cnt = (cfg_pwrup_sel == PWRUP_SEL0) ? OST_SHORT : OST_LONG;
	end

	// divider next values
	always_comb begin
		next_div_cnt  = div_cnt + 8'h01;
		next_osc_tick = 1'b0;
		if (div_cnt >= 8'(OSC_DIV - 1)) begin
			next_div_cnt  = 8'h00;
			next_osc_tick = 1'b1;
		end
	end

	// divider registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			div_cnt  <= 8'h00;
			osc_tick <= 1'b0;
		end else begin
			div_cnt  <= next_div_cnt;
			osc_tick <= next_osc_tick;
		end
	end

	// sequencer next values
	always_comb begin
		next_state             = state;
		next_irq_at_entry      = irq_at_entry;
		next_stop_fast_osc     = stop_fast_osc;
		next_fast_clock_select = fast_clock_select;
		next_timeout_flag      = timeout_flag;
		next_powerdown_flag    = powerdown_flag;
		next_wdt_clear         = 1'b0;
		next_wake_pulse        = 1'b0;
		next_wake_to_vector    = 1'b0;
		next_wake_vector_addr  = wake_vector_addr;
		cif.load               = 1'b0;
		cif.value              = pwrup_cnt;
		cif.tick               = 1'b0;

		if (reset_event) begin
			// flags from the reset cause, por and lvr first
			if (por_s || lvr_s) begin
				next_timeout_flag   = 1'b1;
				next_powerdown_flag = 1'b1;
			end else if (state != ST_RESET) begin
				if (!rst_pin_n_s) begin
					// pin from normal run leaves both flags alone
					if (in_halt) begin
						next_timeout_flag   = 1'b1;
						next_powerdown_flag = 1'b1;
					end
				end else begin
					next_timeout_flag   = 1'b0;
					next_powerdown_flag = !in_halt;
				end
			end
			// defined registers back to reset values
			next_stop_fast_osc = 1'b0;
			next_irq_at_entry  = 1'b0;
			next_state         = ST_RESET;
		end else begin
			unique case (state)
				ST_RESET: begin
					// event released: start power-up wait
					cif.load   = 1'b1;
					cif.value  = pwrup_cnt;
					next_state = ST_PWRUP;
				end
				ST_PWRUP: begin
					cif.tick = 1'b1;
					if (cif.done) begin
						cif.load   = 1'b1;
						cif.value  = ost_cnt;
						next_state = ST_OST;
					end
				end
				ST_OST: begin
					cif.tick = osc_tick;
					if (cif.done) begin
						next_fast_clock_select = cfg_startup_fast;
						next_state             = ST_RUN;
					end
				end
				ST_RUN: begin
					if (osc_wr) begin
						// one write may also enter halt
						next_stop_fast_osc     = stop_fast_osc_wdata;
						next_fast_clock_select = fast_clock_select_wdata;
					end
					if (watchdog_clear_instruction) begin
						next_timeout_flag   = 1'b1;
						next_powerdown_flag = 1'b1;
						next_wdt_clear      = 1'b1;
					end
					if (enter_halt) begin
						next_timeout_flag   = 1'b1;
						next_powerdown_flag = 1'b0;
						next_wdt_clear      = 1'b1;
						next_irq_at_entry   = irq_enabled;
						next_state          = ST_HALT;
					end else if (enter_standby) begin
						next_irq_at_entry = irq_enabled;
						next_state        = ST_STANDBY;
					end
				end
				ST_STANDBY: begin
					if (wake_standby) begin
						// an oscillator kept running, no wait
						next_wake_pulse       = 1'b1;
						next_wake_to_vector   = irq_at_entry;
						next_wake_vector_addr = IRQ_VECTOR;
						next_state            = ST_RUN;
					end
				end
				ST_HALT: begin
					if (wake_halt) begin
						cif.load   = 1'b1;
						cif.value  = any_xtal ? STAB_XTAL : STAB_RC;
						next_state = ST_STAB;
					end
				end
				ST_STAB: begin
					// oscillators restarted, count their cycles
					cif.tick = osc_tick;
					if (cif.done) begin
						next_wake_pulse       = 1'b1;
						next_wake_to_vector   = irq_at_entry;
						next_wake_vector_addr = IRQ_VECTOR;
						next_state            = ST_RUN;
					end
				end
				default: begin
					next_state = ST_RESET;
				end
			endcase
		end
	end

	// output decode from the coming state
	always_comb begin
		next_core_reset  = 1'b0;
		next_cpu_run     = 1'b0;
		next_fast_osc_en = 1'b1;
		next_slow_osc_en = 1'b1;
		next_timer_run   = timer_run_enable;
		next_periph_run  = 1'b1;
		next_sys_mode    = next_fast_clock_select ? MD_NORMAL : MD_SLOW;
		unique case (next_state)
			ST_RESET, ST_PWRUP, ST_OST: begin
				// held in reset until start-up completes
				next_core_reset = 1'b1;
				next_timer_run  = 4'h0;
				next_periph_run = 1'b0;
				next_sys_mode   = cfg_startup_fast ? MD_NORMAL : MD_SLOW;
			end
			ST_RUN: begin
				next_cpu_run     = 1'b1;
				next_fast_osc_en = !next_stop_fast_osc;
			end
			ST_STANDBY: begin
				// cpu stops, slow osc runs, timers by enable
				next_fast_osc_en = !next_stop_fast_osc;
				next_sys_mode    = MD_STANDBY;
			end
			ST_HALT: begin
				// everything stops
				next_fast_osc_en = 1'b0;
				next_slow_osc_en = 1'b0;
				next_timer_run   = 4'h0;
				next_periph_run  = 1'b0;
				next_sys_mode    = MD_HALT;
			end
			ST_STAB: begin
				// oscillators restart, rest still asleep
				next_fast_osc_en = !next_stop_fast_osc || next_fast_clock_select;
				next_timer_run   = 4'h0;
				next_periph_run  = 1'b0;
				next_sys_mode    = MD_HALT;
			end
			default: begin
				next_core_reset = 1'b1;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state             <= ST_RESET;
			irq_at_entry      <= 1'b0;
			core_reset        <= 1'b1;
			cpu_run           <= 1'b0;
			sys_mode          <= MD_NORMAL;
			fast_osc_en       <= 1'b1;
			slow_osc_en       <= 1'b1;
			timer_run         <= 4'h0;
			periph_run        <= 1'b0;
			stop_fast_osc     <= 1'b0;
			fast_clock_select <= SEL_RST;
			timeout_flag      <= TIMEOUT_RST;
			powerdown_flag    <= POWERDOWN_RST;
			wdt_clear         <= 1'b0;
			wake_pulse        <= 1'b0;
			wake_to_vector    <= 1'b0;
			wake_vector_addr  <= 11'h000;
		end else begin
			state             <= next_state;
			irq_at_entry      <= next_irq_at_entry;
			core_reset        <= next_core_reset;
			cpu_run           <= next_cpu_run;
			sys_mode          <= next_sys_mode;
			fast_osc_en       <= next_fast_osc_en;
			slow_osc_en       <= next_slow_osc_en;
			timer_run         <= next_timer_run;
			periph_run        <= next_periph_run;
			stop_fast_osc     <= next_stop_fast_osc;
			fast_clock_select <= next_fast_clock_select;
			timeout_flag      <= next_timeout_flag;
			powerdown_flag    <= next_powerdown_flag;
			wdt_clear         <= next_wdt_clear;
			wake_pulse        <= next_wake_pulse;
			wake_to_vector    <= next_wake_to_vector;
			wake_vector_addr  <= next_wake_vector_addr;
		end
	end
endmodule : pmrs_top

// ### src/pmrs_pkg.sv
// Purpose: shared constants and types of the power mode and reset sequencer
// Assumes: one 100 MHz clock, asynchronous active-low reset
// Notes: counts of clock cycles derive from times printed in ns
package pmrs_pkg;
	localparam int CLK_PERIOD_NS = 10;           // 100 MHz
	localparam int CNT_W         = 25;           // delay counter width
	// power-up times in ns
	localparam int PWRUP0_NS = 140_000;
	localparam int PWRUP1_NS = 4_500_000;
	localparam int PWRUP2_NS = 18_000_000;
	localparam int PWRUP3_NS = 72_000_000;
	localparam int PWRUP4_NS = 288_000_000;
	// least times round up to whole cycles
	localparam int PWRUP0_CYC = (PWRUP0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWRUP1_CYC = (PWRUP1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWRUP2_CYC = (PWRUP2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWRUP3_CYC = (PWRUP3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWRUP4_CYC = (PWRUP4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// oscillator cycle counts
	localparam logic [CNT_W-1:0] OST_SHORT  = 25'h0000001;
	localparam logic [CNT_W-1:0] OST_LONG   = 25'h0000010;
	localparam logic [CNT_W-1:0] STAB_XTAL  = 25'h0000200;
	localparam logic [CNT_W-1:0] STAB_RC    = 25'h0000010;
	localparam logic [2:0]       PWRUP_SEL0 = 3'h0;   // 140 us setting
	// operating-mode field codes
	localparam logic [1:0] OP_MODE_FIELD_HALT    = 2'h1;
	localparam logic [1:0] OP_MODE_FIELD_STANDBY = 2'h2;
	localparam logic [10:0] IRQ_VECTOR  = 11'h008;
	// reset values of the status flags and the clock select
	localparam logic TIMEOUT_RST   = 1'b1;
	localparam logic POWERDOWN_RST = 1'b1;
	localparam logic SEL_RST       = 1'b1;
	typedef enum logic [2:0] {
		ST_RESET   = 3'h0,
		ST_PWRUP   = 3'h1,
		ST_OST     = 3'h2,
		ST_RUN     = 3'h3,
		ST_STANDBY = 3'h4,
		ST_HALT    = 3'h5,
		ST_STAB    = 3'h6
	} pmrs_state_t;
	typedef enum logic [1:0] {
		MD_NORMAL  = 2'h0,
		MD_SLOW    = 2'h1,
		MD_STANDBY = 2'h2,
		MD_HALT    = 2'h3
	} pmrs_mode_t;
endpackage : pmrs_pkg

// ### src/pmrs_cnt_if.sv
// Purpose: link between the sequencer and its delay counter
// Assumes: both ends on the one clock
// Notes: load wins over tick
`timescale 1ns/100ps
interface pmrs_cnt_if;
	import pmrs_pkg::*;
	logic             load;     // start a new wait
	logic [CNT_W-1:0] value;    // ticks to wait
	logic             tick;     // one counted cycle
	logic             done;     // count has reached zero
	modport ctrl (output load, output value, output tick, input done);
	modport cnt  (input load, input value, input tick, output done);
endinterface : pmrs_cnt_if

// ### src/pmrs_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs from outside the clock domain
// Notes: output moves once stages two and three agree
`timescale 1ns/100ps
module pmrs_sync #(
	parameter int       W   = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clock,
	input  wire logic         rstn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1, s2, s3;   // stage flops
	// one synchroniser per bit
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				s1[i] <= INIT[i];
				s2[i] <= INIT[i];
				s3[i] <= INIT[i];
				q[i]  <= INIT[i];
			end else begin
				s1[i] <= d[i];
				s2[i] <= s1[i];
				s3[i] <= s2[i];
				if (s2[i] == s3[i]) begin
					q[i] <= s3[i];
				end
			end
		end
	end
endmodule : pmrs_sync

// ### src/pmrs_delay.sv
// Purpose: down counter for power-up, start-up and wake waits
// Assumes: load and tick from the sequencer
// Notes: done is high while the count is zero
`timescale 1ns/100ps
module pmrs_delay
	import pmrs_pkg::*;
(
	input  wire logic clock,
	input  wire logic rstn,
	pmrs_cnt_if.cnt   cif
);
	logic [CNT_W-1:0] count;       // remaining ticks
	logic [CNT_W-1:0] next_count;
	// next count
	always_comb begin
		next_count = count;
		if (cif.load) begin
			next_count = cif.value;
		end else if (cif.tick && count != '0) begin
			next_count = count - 1'b1;
		end
	end
	// register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
	assign cif.done = (count == '0);
endmodule : pmrs_delay

// ### dv/pmrs_monitor.sv
// Purpose: port checker of the power mode and reset sequencer
// Assumes: one clock domain, rstn low resets everything
// Notes: bound to pmrs_top after the module
`timescale 1ns/100ps
module pmrs_monitor
	import pmrs_pkg::*;
(
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        wdt_reset,
	input wire logic        wdt_timeout,
	input wire logic        port_change,
	input wire logic        osc_wr,
	input wire logic [1:0]  op_mode_field,
	input wire logic        halt_instruction,
	input wire logic        watchdog_clear_instruction,
	input wire logic        irq_enabled,
	input wire logic        core_reset,
	input wire logic        cpu_run,
	input wire pmrs_mode_t  sys_mode,
	input wire logic        fast_osc_en,
	input wire logic        slow_osc_en,
	input wire logic        stop_fast_osc,
	input wire logic        fast_clock_select,
	input wire logic        timeout_flag,
	input wire logic        powerdown_flag,
	input wire logic        wdt_clear,
	input wire logic        wake_pulse,
	input wire logic        wake_to_vector,
	input wire logic [10:0] wake_vector_addr
);
	default clocking mon_cb @(posedge clock); endclocking
	default disable iff (!rstn);
	logic entry_ok;  // a mode write or halt may be taken
	assign entry_ok = cpu_run && !wdt_reset;
	property p_standby_entry;
		entry_ok && osc_wr && op_mode_field == OP_MODE_FIELD_STANDBY && !halt_instruction |=> sys_mode == MD_STANDBY && !cpu_run;
	endproperty
	a_standby_entry: assert property (p_standby_entry) else $error("standby not entered");
	property p_halt_entry;
		entry_ok && (halt_instruction || osc_wr && op_mode_field == OP_MODE_FIELD_HALT)
			|=> sys_mode == MD_HALT && !fast_osc_en && !slow_osc_en && timeout_flag && !powerdown_flag && wdt_clear;
	endproperty
	a_halt_entry: assert property (p_halt_entry) else $error("halt entry wrong");
	property p_standby_osc;
		sys_mode == MD_STANDBY |-> slow_osc_en && fast_osc_en == !stop_fast_osc;
	endproperty
	a_standby_osc: assert property (p_standby_osc) else $error("standby oscillators wrong");
	property p_standby_wake;
		sys_mode == MD_STANDBY && (port_change || wdt_timeout) && !wdt_reset
			|=> wake_pulse && cpu_run && sys_mode == (fast_clock_select ? MD_NORMAL : MD_SLOW);
	endproperty
	a_standby_wake: assert property (p_standby_wake) else $error("standby wake wrong");
	property p_halt_wait;
		sys_mode == MD_HALT && $rose(port_change) |=> !cpu_run [*8] ##[8:520] wake_pulse;
	endproperty
	a_halt_wait: assert property (p_halt_wait) else $error("halt wake wait wrong");
	property p_vector;
		wake_pulse |-> wake_to_vector == irq_enabled && wake_vector_addr == IRQ_VECTOR;
	endproperty
	a_vector: assert property (p_vector) else $error("wake vector wrong");
	property p_clear_wdt;
		entry_ok && watchdog_clear_instruction && !halt_instruction && !osc_wr
			|=> timeout_flag && powerdown_flag && wdt_clear;
	endproperty
	a_clear_wdt: assert property (p_clear_wdt) else $error("watchdog clear flags wrong");
	property p_wdt_reset;
		cpu_run && wdt_reset |=> core_reset && !cpu_run && !timeout_flag && powerdown_flag;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset wrong");
endmodule : pmrs_monitor
bind pmrs_top pmrs_monitor pmrs_monitor_i (.*);

// ### dv/pmrs_periph_model.sv
// Purpose: peripheral side model raising wake events
// Assumes: requests set by the bench one cycle long
// Notes: an event stays pending until the core wakes or the bench clears it
`timescale 1ns/100ps
module pmrs_periph_model (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic [10:0] ev_set,
	input  wire logic        ev_clr,
	input  wire logic        wake_pulse,
	output logic [3:0]       timer_expire,
	output logic             wdt_timeout,
	output logic             port_change,
	output logic [1:0]       external_irq_pins,
	output logic             low_voltage_detect,
	output logic             cmp_change,
	output logic             adc_done
);
	logic [10:0] pend;  // pending requests, held like interrupt flags
	// served requests drop once the core is woken
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			pend <= 11'h000;
		else if (ev_clr || wake_pulse)
			pend <= ev_set;
		else
			pend <= pend | ev_set;
	end
	assign {adc_done, cmp_change, low_voltage_detect, external_irq_pins, port_change, wdt_timeout, timer_expire} = pend;
endmodule : pmrs_periph_model

// ### dv/test_pmrs_top.sv
// Purpose: self-checking bench of the power mode and reset sequencer
// Assumes: shortened power-up counts, inputs move 1 ns after the edge
// Notes: wake events come from the peripheral model
`timescale 1ns/100ps
module test_pmrs_top;
	import pmrs_pkg::*;
	localparam int PW [6] = '{20, 30, 40, 50, 60, 60};  // power-up cycles per setting
	localparam int SB [8] = '{1, 4, 5, 6, 7, 8, 9, 10};  // standby wake sources
	localparam int HS [4] = '{4, 6, 7, 5};               // halt wake sources
	localparam int RK [6] = '{3, 2, 2, 3, 0, 1};         // reset kind
	localparam int RH [6] = '{0, 0, 1, 1, 0, 1};         // reset taken from halt
	localparam int RF [6] = '{1, 1, 3, 0, 3, 3};         // timeout and powerdown after
	logic clock, rstn, por_detect, low_voltage_reset, reset_pin_n, wdt_reset, osc_wr, ev_clr, st;
	logic stop_fast_osc_wdata, fast_clock_select_wdata, halt_instruction, watchdog_clear_instruction;
	logic irq_enabled, cfg_startup_fast, fast_crystal_mode, mid_crystal_mode, slow_crystal_mode;
	logic [1:0] op_mode_field, external_irq_pins;
	logic [2:0] cfg_pwrup_sel;
	logic [3:0] timer_run_enable, timer_expire, timer_run;
	logic [10:0] ev_set, wake_vector_addr;
	logic wdt_timeout, port_change, low_voltage_detect, cmp_change, adc_done, core_reset, cpu_run;
	logic fast_osc_en, slow_osc_en, periph_run, stop_fast_osc, fast_clock_select, timeout_flag;
	logic powerdown_flag, wdt_clear, wake_pulse, wake_to_vector;
	pmrs_mode_t sys_mode;
	int miscompares, check_count, n, e;
	pmrs_top #(.PWRUP0(25'(PW[0])), .PWRUP1(25'(PW[1])), .PWRUP2(25'(PW[2])), .PWRUP3(25'(PW[3])),
		.PWRUP4(25'(PW[4]))) pmrs_top_i (.*);
	pmrs_periph_model pmrs_periph_model_i (.*);
	// free running 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// hang guard
	initial begin
		#200000;
		miscompares++;
		$display("CHECK FAILED at %0t: run too long", $time);
		give_verdict();
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic step(input int k);  // k edges, then settle
		repeat (k) @(posedge clock);
		#1;
	endtask : step
	task automatic wr_mode(input logic [1:0] op, input logic stp, input logic sel);
		step(1);  // idle edge keeps back to back strobes apart
		op_mode_field = op;
		stop_fast_osc_wdata = stp;
		fast_clock_select_wdata = sel;
		osc_wr = 1'b1;
		step(1);
		osc_wr = 1'b0;
	endtask : wr_mode
	task automatic instr(input logic halt);  // one-cycle instruction strobe
		step(1);  // idle edge keeps back to back strobes apart
		halt_instruction = halt;
		watchdog_clear_instruction = !halt;
		step(1);
		{halt_instruction, watchdog_clear_instruction} = 2'h0;
	endtask : instr
	task automatic fire(input int i);  // raise one wake request
		step(1);  // idle edge keeps back to back requests apart
		ev_set = 11'h001 << i;
		step(1);
		ev_set = 11'h000;
	endtask : fire
	task automatic clear_ev();
		step(1);  // idle edge before the clear strobe
		ev_clr = 1'b1;
		step(1);
		ev_clr = 1'b0;
	endtask : clear_ev
	task automatic wait_run(input int lim);  // edges until execution resumes
		n = 0;
		while (cpu_run !== 1'b1 && n < lim) begin
			step(1);
			n++;
		end
		if (n >= lim) begin
			miscompares++;
			$display("CHECK FAILED at %0t: execution never resumed", $time);
		end
	endtask : wait_run
	// main sequence
	initial begin
		{rstn, por_detect, low_voltage_reset, wdt_reset, osc_wr, halt_instruction, ev_clr} = 7'h00;
		{watchdog_clear_instruction, irq_enabled, stop_fast_osc_wdata, op_mode_field} = 5'h00;
		{fast_crystal_mode, mid_crystal_mode, slow_crystal_mode, cfg_pwrup_sel} = 6'h00;
		{reset_pin_n, fast_clock_select_wdata, cfg_startup_fast} = 3'h7;
		timer_run_enable = 4'h2;
		ev_set = 11'h000;
		repeat (10) @(posedge clock);
		#1 rstn = 1'b1;
		wait_run(200);
		chk({stop_fast_osc, wake_vector_addr}, 16'h0000, "reset values");
		for (int s = 0; s < 6; s++) begin
			cfg_pwrup_sel = 3'(s);
			cfg_startup_fast = s[0];
			rstn = 1'b0;
			step(2);
			rstn = 1'b1;
			wait_run(200);
			// four edges flush the synchronised power-on, three step the sequencer
			e = PW[s] + ((s == 0) ? 1 : 16) + 7;
			chk({n >= e - 2, n <= e + 2}, 16'h3, "power-up time");
			chk({timeout_flag, powerdown_flag, fast_clock_select, sys_mode},
				{2'h3, cfg_startup_fast, cfg_startup_fast ? MD_NORMAL : MD_SLOW}, "start state");
		end
		$display("test power_up finished");
		for (int k = 0; k < 8; k++) begin
			st = !k[0] && k[1];
			wr_mode({2{k[2]}}, 1'b0, k[0]);
			wr_mode(2'h0, st, k[0]);
			chk({cpu_run, periph_run, sys_mode}, {2'h3, k[0] ? MD_NORMAL : MD_SLOW}, "mode 00/11 ignored");
			irq_enabled = k[1];
			wr_mode(2'h2, st, k[0]);
			chk({sys_mode, cpu_run, fast_osc_en, slow_osc_en, timer_run}, {MD_STANDBY, 1'b0, !st, 1'b1, 4'h2},
				"standby entry");
			if (k == 0) begin
				fire(0);
				step(4);
				chk(sys_mode, MD_STANDBY, "disabled timer woke");
				clear_ev();
			end
			fire(SB[k]);
			wait_run(20);
			chk({n <= 6, wake_pulse, wake_to_vector, sys_mode}, {2'h3, k[1], k[0] ? MD_NORMAL : MD_SLOW},
				"standby wake");
			if (st)
				wr_mode(2'h0, 1'b0, 1'b0);
		end
		$display("test standby finished");
		for (int c = 0; c < 4; c++) begin
			step(8);  // let a synchronised wake pin fall before halt
			{fast_crystal_mode, mid_crystal_mode, slow_crystal_mode} = (c < 3) ? 3'(4 >> c) : 3'h0;
			irq_enabled = c[0];
			if (c == 1) begin
				wr_mode(2'h0, 1'b0, 1'b0);
				wr_mode(2'h1, 1'b1, 1'b0);
			end else
				instr(1'b1);
			chk({sys_mode, cpu_run, fast_osc_en, slow_osc_en, timer_run, periph_run, timeout_flag, powerdown_flag,
				wdt_clear}, {MD_HALT, 8'h00, 3'h5}, "halt entry");
			fire(1);
			fire(8);
			fire(9);
			fire(10);
			step(3);
			chk({sys_mode, cpu_run}, {MD_HALT, 1'b0}, "halt left on wrong source");
			clear_ev();
			fire(HS[c]);
			wait_run(700);
			e = (c < 3) ? 512 : 16;
			chk({n >= e, n <= e + 10, sys_mode, stop_fast_osc}, {2'h3, (c == 1) ? MD_SLOW : MD_NORMAL, c == 1},
				"halt wake");
			chk({wake_pulse, wake_to_vector, wake_vector_addr}, {1'b1, c[0], IRQ_VECTOR}, "wake vector");
			if (c == 1) begin
				wr_mode(2'h0, 1'b0, 1'b0);
				wr_mode(2'h0, 1'b0, 1'b1);
			end
		end
		instr(1'b0);
		chk({timeout_flag, powerdown_flag, wdt_clear}, 16'h7, "watchdog clear");
		$display("test halt finished");
		for (int r = 0; r < 6; r++) begin
			if (RH[r] == 1)
				instr(1'b1);
			case (RK[r])
				0: por_detect = 1'b1;
				1: low_voltage_reset = 1'b1;
				2: reset_pin_n = 1'b0;
				default: wdt_reset = 1'b1;
			endcase
			step(8);
			chk({core_reset, cpu_run}, 16'h2, "reset held");
			{por_detect, low_voltage_reset, wdt_reset, reset_pin_n} = 4'h1;
			wait_run(300);
			chk({timeout_flag, powerdown_flag}, 16'(RF[r]), "reset flags");
		end
		$display("test reset_flags finished");
		give_verdict();
	end
endmodule : test_pmrs_top
